// ---- core/rtp_pkg.sv ----
package rtp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int STROBE_NS      = 166;
  localparam int LONG_PULSE_NS  = 500;
  localparam int STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_CYC       = (LONG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XFER_CYC       = 12;
  localparam int STROBE_OFS     = (XFER_CYC - STROBE_CYC) / 2;
  localparam int GRANT_WAIT_CYC = 64;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int TR_POS = 10;
  localparam int SA_LSB = 5;
  localparam int WC_LSB = 0;
  localparam logic [4:0] SA_ALL0 = 5'h00;
  localparam logic [4:0] SA_ALL1 = 5'h1f;
  localparam logic [4:0] MC_DBC  = 5'h00;

  // ----------------------------------------------------------------
  // Synchronised pin vector
  // ----------------------------------------------------------------
  localparam int SY_GRANT = 0;
  localparam int SY_ABC   = 1;
  localparam int SY_ILL   = 2;
  localparam int SY_SRQ   = 3;
  localparam int SY_BUSY  = 4;
  localparam int SY_BUFEN = 5;
  localparam int SY_ADDR  = 6;
  localparam int SY_PAR   = 11;
  localparam int SY_DATA  = 12;
  localparam int SY_W     = 28;
  localparam logic [SY_W-1:0] SYNC_RST = 28'h000003f;

  // ----------------------------------------------------------------
  // Status bits and pulse channels
  // ----------------------------------------------------------------
  localparam int STB_ME   = 0;
  localparam int STB_SRQ  = 1;
  localparam int STB_BUSY = 2;
  localparam int STB_DBC  = 3;
  localparam int P_STROBE = 0;
  localparam int P_BIT    = 1;
  localparam int P_NBG    = 2;
  localparam int P_GOOD   = 3;
  localparam int P_NUM    = 4;

  typedef enum logic [2:0] {ST_IDLE, ST_NBG, ST_CMD, ST_ACTIVE, ST_REQ, ST_XFER} rtp_state_e;
endpackage

// ---- core/rtp_pulse_if.sv ----
`timescale 1ns/1ps
interface rtp_pulse_if;
  logic fire;
  logic pulse_n;
  modport gen  (input fire, output pulse_n);
  modport user (output fire, input pulse_n);
endinterface

// ---- core/rtp_pulse_gen.sv ----
`timescale 1ns/1ps
module rtp_pulse_gen #(
  parameter int LEN = 4
) (
  input  wire logic   core_clk_i,
  input  wire logic   rst_i,
  rtp_pulse_if.gen    p
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       pul_q;
  logic       pul_d;

  // ----------------------------------------------------------------
  // Fixed-width low pulse
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    pul_d = pul_q;
    if (p.fire)
    begin
      cnt_d = 4'(LEN - 1);
      pul_d = 1'b1;
    end
    else if (cnt_q != 4'h0)
      cnt_d = cnt_q - 4'h1;
    else
      pul_d = 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 4'h0;
      pul_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pul_q <= pul_d;
    end
  end

  assign p.pulse_n = ~pul_q;
endmodule

// ---- core/rtp_port.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Grant not seen in time drives handshake fail low until next new grant.
// - One low data strobe, about 166 ns, mid each word transfer.
// - Data-not-command low while command word is out, high for data words.
// - Terminal fail latched on self-test or watchdog, released at status word.
// - Request held low until the transfer finishes or times out.
// - Bus control acceptance bit set only for legal dynamic bus control mode.
// - T/R bit and subaddress of the command are latched outputs.
// - Illegal input sampled on in-command rise; sets message error bit.
// - Service request status bit follows its input at each status update.
// - Self-test word enable pulses low about 500 ns with the test word.
// - New grant pulses low about 166 ns at each new command sequence.
// - Terminal address plus parity must be odd for the terminal to work.
// - Word count lines show latched count or the current word counter.
// - Acknowledge low while a granted transfer is being performed.
// - Buffer direction high only to fetch transmit words, and only while requesting.
// - Good receive block gives a low pulse of about 500 ns.
// - All logic runs from one master clock.
// - Buffer enable low lets the buffers drive; high floats them.
// - The reset input resets the whole terminal logic.
// - The data bus is 16 bits wide and bidirectional, bit 0 lowest.
// - In-command is high while a command is being serviced.
// - With busy set, no transmit data is requested; receive data still flows.
// - Any message error drives message error low until the next new grant.
module rtp_port (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] data_bus_i,
  output logic      [15:0] data_bus_o,
  output logic             data_bus_oe_o,
  output logic             transfer_request_n_o,
  input  wire logic        transfer_grant_n_i,
  output logic             transfer_ack_n_o,
  output logic             data_strobe_n_o,
  output logic             data_not_command_o,
  output logic             buffer_direction_o,
  input  wire logic        buffer_enable_n_i,
  output logic             in_command_o,
  output logic             tr_bit_out_o,
  output logic      [4:0]  subaddress_o,
  output logic      [4:0]  word_count_o,
  output logic             handshake_fail_n_o,
  output logic             message_error_n_o,
  output logic             terminal_fail_n_o,
  output logic             new_grant_pulse_n_o,
  output logic             selftest_word_enable_n_o,
  output logic             good_block_pulse_n_o,
  input  wire logic        accept_bus_control_n_i,
  input  wire logic        illegal_command_n_i,
  input  wire logic        service_request_in_n_i,
  input  wire logic        busy_in_n_i,
  input  wire logic [4:0]  terminal_address_i,
  input  wire logic        address_parity_in_i,
  input  wire logic        cmd_strobe_i,
  input  wire logic [15:0] cmd_word_i,
  input  wire logic        rx_word_valid_i,
  input  wire logic [15:0] rx_word_i,
  output logic             rx_word_ready_o,
  input  wire logic        tx_word_req_i,
  output logic             tx_word_valid_o,
  output logic      [15:0] tx_word_o,
  input  wire logic        msg_done_i,
  input  wire logic        wc_ok_i,
  input  wire logic        msg_error_event_i,
  input  wire logic        status_update_i,
  output logic      [3:0]  status_bits_o,
  input  wire logic        selftest_fail_i,
  input  wire logic        watchdog_timeout_i,
  input  wire logic        bit_word_show_i,
  input  wire logic [15:0] bit_word_i,
  output logic             terminal_ok_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [rtp_pkg::SY_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, pins;

  assign pins = {data_bus_i, address_parity_in_i, terminal_address_i, buffer_enable_n_i,
                 busy_in_n_i, service_request_in_n_i, illegal_command_n_i,
                 accept_bus_control_n_i, transfer_grant_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < rtp_pkg::SY_W; gi++)
    begin : g_sync
      always_comb
      begin
        filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : filt_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s1_q   <= rtp_pkg::SYNC_RST;
      s2_q   <= rtp_pkg::SYNC_RST;
      s3_q   <= rtp_pkg::SYNC_RST;
      filt_q <= rtp_pkg::SYNC_RST;
    end
    else
    begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  logic        grant_s, bufen_n_s;
  logic [15:0] data_s;
  assign grant_s   = ~filt_q[rtp_pkg::SY_GRANT];
  assign bufen_n_s = filt_q[rtp_pkg::SY_BUFEN];
  assign data_s    = filt_q[rtp_pkg::SY_DATA +: rtp_pkg::DATA_W];
  assign terminal_ok_o = ^filt_q[rtp_pkg::SY_PAR:rtp_pkg::SY_ADDR];

  // ----------------------------------------------------------------
  // Pulse generators
  // ----------------------------------------------------------------
  rtp_pulse_if pif [rtp_pkg::P_NUM] ();
  logic [rtp_pkg::P_NUM-1:0] fire;

  generate
    for (gi = 0; gi < rtp_pkg::P_NUM; gi++)
    begin : g_pulse
      assign pif[gi].fire = fire[gi];
      rtp_pulse_gen #(
        .LEN ((gi == rtp_pkg::P_BIT || gi == rtp_pkg::P_GOOD) ?
              rtp_pkg::LONG_CYC : rtp_pkg::STROBE_CYC)
      ) u_pulse (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .p          (pif[gi])
      );
    end
  endgenerate

  assign data_strobe_n_o          = pif[rtp_pkg::P_STROBE].pulse_n;
  assign selftest_word_enable_n_o = pif[rtp_pkg::P_BIT].pulse_n;
  assign new_grant_pulse_n_o      = pif[rtp_pkg::P_NBG].pulse_n;
  assign good_block_pulse_n_o     = pif[rtp_pkg::P_GOOD].pulse_n;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rtp_pkg::rtp_state_e state_q, state_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [15:0] cmd_q, cmd_d, bus_q, bus_d, txw_q, txw_d;
  logic [4:0]  wcnt_q, wcnt_d;
  logic [3:0]  sbits_q, sbits_d;
  logic        dir_q, dir_d, dnc_q, dnc_d, svc_q, svc_d, txv_q, txv_d;
  logic        hsf_q, hsf_d, me_q, me_d, tf_q, tf_d, ill_q, ill_d;
  logic        is_mode, strobe_at, capture_at, good;

  assign is_mode    = (cmd_q[rtp_pkg::SA_LSB +: 5] == rtp_pkg::SA_ALL0) ||
                      (cmd_q[rtp_pkg::SA_LSB +: 5] == rtp_pkg::SA_ALL1);
  assign strobe_at  = cnt_q == 8'(rtp_pkg::XFER_CYC - 1 - rtp_pkg::STROBE_OFS);
  assign capture_at = cnt_q == 8'(rtp_pkg::XFER_CYC - 1 - rtp_pkg::STROBE_OFS
                                  - rtp_pkg::STROBE_CYC);
  assign good = ~cmd_q[rtp_pkg::TR_POS] && !is_mode && !ill_q && !me_q && !hsf_q
                && wc_ok_i && (wcnt_q == cmd_q[rtp_pkg::WC_LSB +: 5]);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
    cmd_d   = cmd_q;
    bus_d   = bus_q;
    txw_d   = txw_q;
    wcnt_d  = wcnt_q;
    sbits_d = sbits_q;
    dir_d   = dir_q;
    dnc_d   = dnc_q;
    svc_d   = svc_q;
    txv_d   = 1'b0;
    hsf_d   = hsf_q;
    me_d    = me_q;
    tf_d    = tf_q;
    ill_d   = ill_q;
    fire    = '0;
    case (state_q)
      rtp_pkg::ST_IDLE:
      begin
        if (cmd_strobe_i && terminal_ok_o)
        begin
          cmd_d   = cmd_word_i;
          wcnt_d  = 5'h00;
          ill_d   = 1'b0;
          cnt_d   = 8'(rtp_pkg::STROBE_CYC - 1);
          fire[rtp_pkg::P_NBG] = 1'b1;
          hsf_d   = 1'b0;
          me_d    = 1'b0;
          state_d = rtp_pkg::ST_NBG;
        end
      end
      rtp_pkg::ST_NBG:
      begin
        if (cnt_q == 8'h00)
        begin
          bus_d   = cmd_q;
          dnc_d   = 1'b0;
          cnt_d   = 8'(rtp_pkg::XFER_CYC - 1);
          state_d = rtp_pkg::ST_CMD;
        end
      end
      rtp_pkg::ST_CMD:
      begin
        fire[rtp_pkg::P_STROBE] = strobe_at;
        if (cnt_q == 8'h00)
        begin
          svc_d   = 1'b1;
          dnc_d   = 1'b1;
          state_d = rtp_pkg::ST_ACTIVE;
        end
      end
      rtp_pkg::ST_ACTIVE:
      begin
        if (msg_done_i)
        begin
          svc_d   = 1'b0;
          fire[rtp_pkg::P_GOOD] = good;
          state_d = rtp_pkg::ST_IDLE;
        end
        else if (rx_word_valid_i)
        begin
          bus_d   = rx_word_i;
          cnt_d   = 8'(rtp_pkg::GRANT_WAIT_CYC - 1);
          state_d = rtp_pkg::ST_REQ;
        end
        else if (tx_word_req_i)
        begin
          if (sbits_q[rtp_pkg::STB_BUSY])
          begin
            txw_d = 16'h0000;
            txv_d = 1'b1;
          end
          else
          begin
            dir_d   = 1'b1;
            cnt_d   = 8'(rtp_pkg::GRANT_WAIT_CYC - 1);
            state_d = rtp_pkg::ST_REQ;
          end
        end
      end
      rtp_pkg::ST_REQ:
      begin
        if (grant_s)
        begin
          cnt_d   = 8'(rtp_pkg::XFER_CYC - 1);
          state_d = rtp_pkg::ST_XFER;
        end
        else if (cnt_q == 8'h00)
        begin
          hsf_d   = 1'b1;
          txw_d   = 16'h0000;
          txv_d   = dir_q;
          dir_d   = 1'b0;
          state_d = rtp_pkg::ST_ACTIVE;
        end
      end
      rtp_pkg::ST_XFER:
      begin
        fire[rtp_pkg::P_STROBE] = strobe_at;
        if (capture_at && dir_q)
          txw_d = data_s;
        if (cnt_q == 8'h00)
        begin
          wcnt_d  = wcnt_q + 5'h01;
          txv_d   = dir_q;
          dir_d   = 1'b0;
          state_d = rtp_pkg::ST_ACTIVE;
        end
      end
      default:
        state_d = rtp_pkg::ST_IDLE;
    endcase
    if (bit_word_show_i && (state_q == rtp_pkg::ST_IDLE || state_q == rtp_pkg::ST_ACTIVE)
        && !rx_word_valid_i)
    begin
      bus_d = bit_word_i;
      fire[rtp_pkg::P_BIT] = 1'b1;
    end
    if (svc_d && !svc_q)
      ill_d = ~filt_q[rtp_pkg::SY_ILL];
    if (msg_error_event_i || (ill_d && !ill_q))
      me_d = 1'b1;
    // release at status word, fault wins
    if (status_update_i)
      tf_d = 1'b0;
    if (selftest_fail_i || watchdog_timeout_i)
      tf_d = 1'b1;
    if (status_update_i)
    begin
      sbits_d[rtp_pkg::STB_ME]   = ill_q | me_q;
      sbits_d[rtp_pkg::STB_SRQ]  = ~filt_q[rtp_pkg::SY_SRQ];
      sbits_d[rtp_pkg::STB_BUSY] = ~filt_q[rtp_pkg::SY_BUSY];
      sbits_d[rtp_pkg::STB_DBC]  = ~filt_q[rtp_pkg::SY_ABC] && is_mode && !ill_q &&
                                   (cmd_q[rtp_pkg::WC_LSB +: 5] == rtp_pkg::MC_DBC);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= rtp_pkg::ST_IDLE;
      cnt_q   <= 8'h00;
      cmd_q   <= 16'h0000;
      bus_q   <= 16'h0000;
      txw_q   <= 16'h0000;
      wcnt_q  <= 5'h00;
      sbits_q <= 4'h0;
      dir_q   <= 1'b0;
      dnc_q   <= 1'b1;
      svc_q   <= 1'b0;
      txv_q   <= 1'b0;
      hsf_q   <= 1'b0;
      me_q    <= 1'b0;
      tf_q    <= 1'b0;
      ill_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cmd_q   <= cmd_d;
      bus_q   <= bus_d;
      txw_q   <= txw_d;
      wcnt_q  <= wcnt_d;
      sbits_q <= sbits_d;
      dir_q   <= dir_d;
      dnc_q   <= dnc_d;
      svc_q   <= svc_d;
      txv_q   <= txv_d;
      hsf_q   <= hsf_d;
      me_q    <= me_d;
      tf_q    <= tf_d;
      ill_q   <= ill_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // request until done or timeout
  assign transfer_request_n_o = ~(state_q == rtp_pkg::ST_REQ || state_q == rtp_pkg::ST_XFER);
  assign transfer_ack_n_o     = ~(state_q == rtp_pkg::ST_XFER);
  assign buffer_direction_o   = dir_q;
  assign data_bus_oe_o        = ~dir_q & ~bufen_n_s;
  assign data_bus_o           = bus_q;
  assign data_not_command_o   = dnc_q;
  assign in_command_o         = svc_q;
  assign tr_bit_out_o         = cmd_q[rtp_pkg::TR_POS];
  assign subaddress_o         = cmd_q[rtp_pkg::SA_LSB +: 5];
  assign word_count_o         = (!svc_q || is_mode) ? cmd_q[rtp_pkg::WC_LSB +: 5] : wcnt_q;
  assign handshake_fail_n_o   = ~hsf_q;
  assign message_error_n_o    = ~me_q;
  assign terminal_fail_n_o    = ~tf_q;
  assign status_bits_o        = sbits_q[3:0];
  assign rx_word_ready_o      = (state_q == rtp_pkg::ST_ACTIVE) && !msg_done_i;
  assign tx_word_valid_o      = txv_q;
  assign tx_word_o            = txw_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  grant_late_a: assert property (
    state_q == rtp_pkg::ST_REQ && cnt_q == 8'h00 && !grant_s |=> !handshake_fail_n_o)
    else $error("handshake fail not raised");
  strobe_len_a: assert property (
    $fell(data_strobe_n_o) |-> !data_strobe_n_o[*4] ##1 data_strobe_n_o)
    else $error("strobe width");
  dnc_cmd_a: assert property (
    state_q == rtp_pkg::ST_CMD |-> !data_not_command_o)
    else $error("command word flag");
  term_fail_a: assert property (
    selftest_fail_i || watchdog_timeout_i |=> !terminal_fail_n_o)
    else $error("terminal fail not set");
  ack_grant_a: assert property (
    $fell(transfer_ack_n_o) |-> $past(grant_s) && $past(transfer_request_n_o) == 1'b0)
    else $error("ack without grant");
  dir_req_a: assert property (
    buffer_direction_o |-> !transfer_request_n_o && !data_bus_oe_o)
    else $error("direction");
  nbg_len_a: assert property (
    $fell(new_grant_pulse_n_o) |-> !new_grant_pulse_n_o[*4] ##1 new_grant_pulse_n_o)
    else $error("grant pulse");
  bit_len_a: assert property (
    $fell(selftest_word_enable_n_o)
    |-> ##9 !selftest_word_enable_n_o ##1 selftest_word_enable_n_o)
    else $error("test word pulse");
  parity_gate_a: assert property (
    state_q == rtp_pkg::ST_IDLE && cmd_strobe_i && !terminal_ok_o
    |=> state_q == rtp_pkg::ST_IDLE)
    else $error("bad parity answered");
  wc_mux_a: assert property (
    !in_command_o |-> word_count_o == cmd_q[4:0])
    else $error("count lines");

  cmd_seen_c: cover property ($fell(new_grant_pulse_n_o) ##[1:20] $fell(data_strobe_n_o));
  xfer_c: cover property ($fell(transfer_ack_n_o) ##[1:12] $fell(data_strobe_n_o));
  timeout_c: cover property ($fell(handshake_fail_n_o));
  good_c: cover property ($fell(good_block_pulse_n_o));
endmodule

// ---- tb/rtp_host_model.sv ----
`timescale 1ns/1ps
module rtp_host_model (
  input  wire logic        core_clk_i,
  input  wire logic        transfer_request_n_i,
  input  wire logic        transfer_ack_n_i,
  input  wire logic        buffer_direction_i,
  input  wire logic        data_strobe_n_i,
  input  wire logic [15:0] bus_i,
  input  wire logic        no_grant_i,
  input  wire logic [15:0] tx_data_i,
  output logic             transfer_grant_n_o,
  output logic             host_oe_o,
  output logic      [15:0] host_data_o,
  output logic      [15:0] captured_o
);
  initial
  begin
    transfer_grant_n_o = 1'b1;
    captured_o = 16'h0000;
  end
  always @(posedge core_clk_i)
    transfer_grant_n_o <= transfer_request_n_i | no_grant_i | ~transfer_ack_n_i;
  always @(posedge data_strobe_n_i)
    if (!buffer_direction_i)
      captured_o <= bus_i;
  assign host_oe_o   = buffer_direction_i;
  assign host_data_o = tx_data_i;
endmodule

// ---- tb/tb_rtp_port.sv ----
`timescale 1ns/1ps
module tb_rtp_port;
  logic core_clk_i, rst_i = 1'b1, rx_word_ready_o, tx_word_valid_o, terminal_ok_o, data_bus_oe_o;
  logic transfer_request_n_o, transfer_grant_n_i, transfer_ack_n_o, data_strobe_n_o;
  logic data_not_command_o, buffer_direction_o, in_command_o, tr_bit_out_o;
  logic handshake_fail_n_o, message_error_n_o, terminal_fail_n_o, new_grant_pulse_n_o;
  logic selftest_word_enable_n_o, good_block_pulse_n_o, host_oe;
  logic [15:0] data_bus_i, data_bus_o, tx_word_o, host_data, captured;
  logic [4:0]  subaddress_o, word_count_o, wc_seen;
  logic [3:0]  status_bits_o;
  logic buffer_enable_n_i = 1'b0, accept_bus_control_n_i = 1'b1, illegal_command_n_i = 1'b1;
  logic service_request_in_n_i = 1'b1, busy_in_n_i = 1'b1, address_parity_in_i = 1'b1;
  logic cmd_strobe_i = 1'b0, rx_word_valid_i = 1'b0, tx_word_req_i = 1'b0, msg_done_i = 1'b0;
  logic wc_ok_i = 1'b1, msg_error_event_i = 1'b0, status_update_i = 1'b0, no_grant = 1'b0;
  logic selftest_fail_i = 1'b0, watchdog_timeout_i = 1'b0, bit_word_show_i = 1'b0;
  logic [4:0]  terminal_address_i = 5'h01;
  logic [15:0] cmd_word_i = 16'h0000, rx_word_i = 16'h5a3c, bit_word_i = 16'h1234;
  logic [15:0] host_tx = 16'hc35a, tx_seen;
  int miscompares = 0, n_compared = 0, c_nbg, c_dnc, c_ack, c_stb, c_long, bad_dir;

  assign data_bus_i = host_oe ? host_data : (data_bus_oe_o ? data_bus_o : ~data_bus_o);

  rtp_port i_rtp_port (.*);

  rtp_host_model i_rtp_host_model (
    .core_clk_i           (core_clk_i),
    .transfer_request_n_i (transfer_request_n_o),
    .transfer_ack_n_i     (transfer_ack_n_o),
    .buffer_direction_i   (buffer_direction_o),
    .data_strobe_n_i      (data_strobe_n_o),
    .bus_i                (data_bus_i),
    .no_grant_i           (no_grant),
    .tx_data_i            (host_tx),
    .transfer_grant_n_o   (transfer_grant_n_i),
    .host_oe_o            (host_oe),
    .host_data_o          (host_data),
    .captured_o           (captured)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic clr;
    {c_nbg, c_dnc, c_ack, c_stb, c_long, bad_dir} = '0;
  endtask

  // Step n falling edges, counting low cycles of the pulse outputs
  task automatic run(input int n);
    repeat (n)
    begin
      @(negedge core_clk_i);
      c_nbg += int'(new_grant_pulse_n_o === 1'b0);
      c_dnc += int'(data_not_command_o === 1'b0);
      c_ack += int'(transfer_ack_n_o === 1'b0);
      c_stb += int'(data_strobe_n_o === 1'b0);
      c_long += int'(good_block_pulse_n_o === 1'b0) + int'(selftest_word_enable_n_o === 1'b0);
      if (data_not_command_o === 1'b0)
        wc_seen = word_count_o;
      if (tx_word_valid_o === 1'b1)
        tx_seen = tx_word_o;
      if (buffer_direction_o === 1'b1 && transfer_request_n_o !== 1'b0)
        bad_dir++;
    end
  endtask

  task automatic send_cmd(input logic [15:0] w);
    clr();
    cmd_strobe_i = 1'b1;
    cmd_word_i = w;
    run(1);
    cmd_strobe_i = 1'b0;
    run(24);
  endtask

  task automatic end_msg;
    msg_done_i = 1'b1;
    run(1);
    msg_done_i = 1'b0;
    run(16);
  endtask

  task automatic t_reset;
    repeat (16) @(negedge core_clk_i);
    rst_i = 1'b0;
    run(8);
    check(transfer_request_n_o, 1'b1, "request after reset");
    check({in_command_o, data_not_command_o}, 2'h1, "command lines after reset");
    check(terminal_ok_o, 1'b0, "even parity accepted");
    send_cmd(16'h00a1);
    check(c_nbg, 0, "command served with bad parity");
    address_parity_in_i = 1'b0;
    run(8);
    check(terminal_ok_o, 1'b1, "odd parity refused");
    $display("test reset done");
  endtask

  task automatic t_receive;
    send_cmd(16'h00a1);
    check(c_nbg, 4, "new grant width");
    check(c_dnc, 12, "command phase length");
    check(c_stb, 4, "command strobe width");
    check(captured, 16'h00a1, "command word on bus");
    check(wc_seen, 5'h01, "latched word count");
    check({in_command_o, tr_bit_out_o, subaddress_o}, 7'h45, "latched command");
    check(word_count_o, 5'h00, "word counter at start");
    clr();
    rx_word_valid_i = 1'b1;
    run(1);
    rx_word_valid_i = 1'b0;
    run(40);
    check(c_ack, 12, "acknowledge length");
    check(c_stb, 4, "data strobe width");
    check(captured, 16'h5a3c, "word to host");
    check(word_count_o, 5'h01, "word counter step");
    clr();
    end_msg();
    check(c_long, 10, "good block width");
    check(in_command_o, 1'b0, "in command after end");
    $display("test receive done");
  endtask

  task automatic t_transmit;
    send_cmd(16'h04a1);
    check(tr_bit_out_o, 1'b1, "transmit bit");
    clr();
    tx_word_req_i = 1'b1;
    run(1);
    tx_word_req_i = 1'b0;
    run(40);
    check(tx_seen, 16'hc35a, "word from host");
    check(bad_dir, 0, "direction without request");
    check(c_ack, 12, "acknowledge length");
    end_msg();
    $display("test transmit done");
  endtask

  task automatic t_fail;
    send_cmd(16'h00a1);
    no_grant = 1'b1;
    msg_error_event_i = 1'b1;
    run(1);
    msg_error_event_i = 1'b0;
    rx_word_valid_i = 1'b1;
    run(1);
    rx_word_valid_i = 1'b0;
    run(90);
    check(handshake_fail_n_o, 1'b0, "no handshake fail");
    check(transfer_request_n_o, 1'b1, "request kept after timeout");
    check(message_error_n_o, 1'b0, "no message error");
    no_grant = 1'b0;
    end_msg();
    send_cmd(16'h00a1);
    check(handshake_fail_n_o, 1'b1, "handshake fail kept");
    check(message_error_n_o, 1'b1, "message error kept");
    end_msg();
    $display("test fail done");
  endtask

  task automatic t_status;
    selftest_fail_i = 1'b1;
    run(1);
    selftest_fail_i = 1'b0;
    service_request_in_n_i = 1'b0;
    run(8);
    check(terminal_fail_n_o, 1'b0, "terminal fail not set");
    status_update_i = 1'b1;
    run(1);
    status_update_i = 1'b0;
    run(4);
    check(status_bits_o[1], 1'b1, "service request bit");
    check(terminal_fail_n_o, 1'b1, "terminal fail not released");
    clr();
    bit_word_show_i = 1'b1;
    run(1);
    bit_word_show_i = 1'b0;
    run(16);
    check(c_long, 10, "test word enable width");
    check(data_bus_o, 16'h1234, "test word on bus");
    $display("test status done");
  endtask

  task automatic t_mode;
    busy_in_n_i = 1'b0;
    accept_bus_control_n_i = 1'b0;
    send_cmd(16'h0400);
    status_update_i = 1'b1;
    run(1);
    status_update_i = 1'b0;
    run(2);
    check(status_bits_o, 4'he, "bus control accept and busy bits");
    clr();
    tx_word_req_i = 1'b1;
    run(1);
    tx_word_req_i = 1'b0;
    run(8);
    check(tx_seen, 16'h0000, "busy word");
    check(c_ack, 0, "data requested while busy");
    check(rx_word_ready_o, 1'b1, "receive path blocked while busy");
    end_msg();
    illegal_command_n_i = 1'b0;
    send_cmd(16'h07ff);
    check(word_count_o, 5'h1f, "mode count lines");
    check(message_error_n_o, 1'b0, "illegal command not flagged");
    status_update_i = 1'b1;
    run(1);
    status_update_i = 1'b0;
    run(2);
    check(status_bits_o, 4'h7, "illegal command status");
    buffer_enable_n_i = 1'b1;
    run(5);
    check(data_bus_oe_o, 1'b0, "buffers not floated");
    end_msg();
    $display("test mode done");
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(50 * 4000);
    miscompares++;
    stop_test();
  end

  initial
  begin
    t_reset();
    t_receive();
    t_transmit();
    t_fail();
    t_status();
    t_mode();
    stop_test();
  end
endmodule
